// ===== pgao_pkg.sv
/*
 Package for the pulse generator / assignable output block: register
 offsets, field layouts, reset values, mode codes and timing counts.
 Assumes a 100 MHz system clock and an APB slave with 32-bit words.
*/
package pgao_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_RATE = 8'h00;
   localparam logic [7:0] OFS_ACCESS = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_ASSIGN = 8'h0C;
   localparam logic [7:0] OFS_INVERT = 8'h10;
   localparam logic [7:0] OFS_POLARITY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_PANEL_RATE = 8'h24;

   localparam int RATE_W = 14;
   localparam logic [13:0] RATE_MAX = 14'h270F;
   localparam logic [13:0] RATE_RST = 14'h0000;
   localparam logic [1:0] ACCESS_RST = 2'h0;
   localparam logic [1:0] ACCESS_CODE = 2'h2;
   localparam logic [1:0] ACCESS_FREE = 2'h3;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam int COND_STALL = 0;
   localparam int IRQ_W = 3;
   localparam int IRQ_PULSE = 0;
   localparam int IRQ_OUT_CHG = 1;
   localparam int IRQ_PANEL_REJ = 2;

   // Half a minute of clock cycles; a whole minute overflows 32 bits
   localparam longint CLK_HZ = 64'h0000_0000_05F5_E100;
   localparam longint SEC_PER_MIN = 64'h0000_0000_0000_003C;
   localparam logic [31:0] TICKS_HALF_MIN = 32'((CLK_HZ * SEC_PER_MIN) >> 1);

   typedef enum logic [0:0] {
      PGAO_MODE_GEN = 1'b0,
      PGAO_MODE_LOGIC = 1'b1
   } pgao_mode_t;

   typedef enum logic [0:0] {
      PGAO_POL_NO = 1'b0,
      PGAO_POL_NC = 1'b1
   } pgao_pol_t;

   typedef struct packed {
      logic [7:0] assign_mask;
      logic [7:0] invert_mask;
      pgao_pol_t polarity;
   } pgao_logic_cfg_t;
endpackage : pgao_pkg

// ===== pgao_rate_gen.sv
/*
 Pulse rate generator: phase accumulator producing a square wave at the
 programmed pulses per minute. Assumes rate is already range-checked.
*/
`timescale 1ns/1ps
`default_nettype none
module pgao_rate_gen (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [13:0] rate,
   output logic wave,
   output logic pulse
);
   logic [31:0] acc_r;
   logic [31:0] acc_nxt;
   logic [32:0] sum;
   logic wrap;
   logic wave_r;

   // Accumulator adds rate each cycle; wraps twice per output period
   assign sum = {1'b0, acc_r} + {19'h0_0000, rate};
   assign wrap = sum >= {1'b0, pgao_pkg::TICKS_HALF_MIN};
   assign acc_nxt = wrap
      ? 32'(sum - {1'b0, pgao_pkg::TICKS_HALF_MIN}) : sum[31:0];

   always_ff @(posedge clk_sys) begin
      if (reset || rate == 14'h0000) begin
         acc_r <= 32'h0000_0000;
         wave_r <= 1'b0;
         pulse <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         if (wrap) begin
            wave_r <= ~wave_r;
         end
         pulse <= wrap & ~wave_r;
      end
   end
   assign wave = wave_r;
endmodule : pgao_rate_gen
`default_nettype wire

// ===== pgao_top.sv
/*
 Shared open-collector output: pulse generator or assignable logic
 output, with APB registers and a masked interrupt.
 Assumes drive status bits are synchronous to clk_sys; panel edit
 strobe comes from a pin and is synchronised here.
*/
// The implementer's own choices: the register offsets and the APB slave port.
// Summary of operation
// - Generator rate 0 to 9999 pulses per minute
// - Rate register write changes the pulse rate
// - Panel rate edits only at access 2 or 3
// - Own pulses may serve as leader reference
// - Output is generator or logic, never both
// - Assignment mask selects up to eight conditions
// - Conditions equal the drive status bits
// - Invert mask complements chosen condition bits
// - Polarity selects normally open or closed
// - Selected conditions combine by logical OR
// - Mask bit n-1 is switch n
// - Assignment bit zero is pickup stalled
// - Polarity zero means normally open
`timescale 1ns/1ps
`default_nettype none
module pgao_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] drive_status,
   input wire logic panel_edit,
   input wire logic [13:0] panel_rate,
   input wire logic leader_self,
   output logic out_drive,
   output logic leader_ref,
   output logic irq
);
   logic [13:0] rate_r;
   logic [1:0] access_r;
   pgao_pkg::pgao_mode_t mode_r;
   pgao_pkg::pgao_logic_cfg_t cfg_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_mask_r;
   logic [2:0] irq_ev;
   logic [1:0] edit_sync_r;
   logic edit_d_r;
   logic edit_rise;
   logic [13:0] prate_s1_r;
   logic [13:0] prate_s2_r;
   logic panel_ok;
   logic gen_wave;
   logic gen_pulse;
   logic [7:0] cond;
   logic any_cond;
   logic logic_out;
   logic out_nxt;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rd_nxt;
   logic [13:0] wrate;
   logic wrate_ok;
   logic prate_ok;
   logic panel_rej;

   pgao_rate_gen u_gen (
      .clk_sys(clk_sys),
      .reset(reset),
      .rate(rate_r),
      .wave(gen_wave),
      .pulse(gen_pulse)
   );

   // Bus decode
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign addr_ok = paddr == pgao_pkg::OFS_RATE
      || paddr == pgao_pkg::OFS_ACCESS
      || paddr == pgao_pkg::OFS_MODE
      || paddr == pgao_pkg::OFS_ASSIGN
      || paddr == pgao_pkg::OFS_INVERT
      || paddr == pgao_pkg::OFS_POLARITY
      || paddr == pgao_pkg::OFS_STATUS
      || paddr == pgao_pkg::OFS_IRQ_STAT
      || paddr == pgao_pkg::OFS_IRQ_MASK
      || paddr == pgao_pkg::OFS_PANEL_RATE;
   assign wrate = pwdata[13:0];
   assign wrate_ok = wrate <= pgao_pkg::RATE_MAX
      && pwdata[31:14] == '0;

   // Panel strobe from a pin: two flops before any use
   assign edit_rise = edit_sync_r[1] & ~edit_d_r;
   assign panel_ok = access_r == pgao_pkg::ACCESS_CODE
      || access_r == pgao_pkg::ACCESS_FREE;
   assign prate_ok = prate_s2_r <= pgao_pkg::RATE_MAX;
   assign panel_rej = edit_rise & ~(panel_ok & prate_ok);

   // Assignable logic path
   assign cond = (drive_status ^ cfg_r.invert_mask)
      & cfg_r.assign_mask;
   assign any_cond = |cond;
   assign logic_out = (cfg_r.polarity == pgao_pkg::PGAO_POL_NC)
      ? ~any_cond : any_cond;
   assign out_nxt = (mode_r == pgao_pkg::PGAO_MODE_LOGIC)
      ? logic_out : gen_wave;

   assign irq_ev[pgao_pkg::IRQ_PULSE] = gen_pulse
      & (mode_r == pgao_pkg::PGAO_MODE_GEN);
   assign irq_ev[pgao_pkg::IRQ_OUT_CHG] = out_nxt ^ out_drive;
   assign irq_ev[pgao_pkg::IRQ_PANEL_REJ] = panel_rej;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         pgao_pkg::OFS_RATE: rd_nxt = {18'h0_0000, rate_r};
         pgao_pkg::OFS_ACCESS: rd_nxt = {30'h0000_0000, access_r};
         pgao_pkg::OFS_MODE: rd_nxt = {31'h0000_0000, mode_r};
         pgao_pkg::OFS_ASSIGN: rd_nxt = {24'h00_0000, cfg_r.assign_mask};
         pgao_pkg::OFS_INVERT: rd_nxt = {24'h00_0000, cfg_r.invert_mask};
         pgao_pkg::OFS_POLARITY: rd_nxt = {31'h0000_0000, cfg_r.polarity};
         pgao_pkg::OFS_STATUS: rd_nxt = {23'h00_0000, out_drive,
            drive_status};
         pgao_pkg::OFS_IRQ_STAT: rd_nxt = {29'h0000_0000, irq_stat_r};
         pgao_pkg::OFS_IRQ_MASK: rd_nxt = {29'h0000_0000, irq_mask_r};
         pgao_pkg::OFS_PANEL_RATE: rd_nxt = {18'h0_0000, prate_s2_r};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // APB answer: single-cycle access phase
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         edit_sync_r <= 2'h0;
         edit_d_r <= 1'b0;
         prate_s1_r <= 14'h0000;
         prate_s2_r <= 14'h0000;
      end else begin
         edit_sync_r <= {edit_sync_r[0], panel_edit};
         edit_d_r <= edit_sync_r[1];
         prate_s1_r <= panel_rate;
         prate_s2_r <= prate_s1_r;
      end
   end

   // Rate: last of bus or panel write wins; panel wins on same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rate_r <= pgao_pkg::RATE_RST;
      end else if (edit_rise && panel_ok && prate_ok) begin
         rate_r <= prate_s2_r;
      end else if (wr_en && pready && paddr == pgao_pkg::OFS_RATE
         && wrate_ok) begin
         rate_r <= wrate;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         access_r <= pgao_pkg::ACCESS_RST;
         mode_r <= pgao_pkg::PGAO_MODE_GEN;
         cfg_r <= {pgao_pkg::MASK_RST, pgao_pkg::MASK_RST,
            pgao_pkg::PGAO_POL_NO};
         irq_mask_r <= 3'h0;
      end else if (wr_en && pready) begin
         case (paddr)
            pgao_pkg::OFS_ACCESS: access_r <= pwdata[1:0];
            pgao_pkg::OFS_MODE: mode_r <= pgao_pkg::pgao_mode_t'(pwdata[0]);
            pgao_pkg::OFS_ASSIGN: cfg_r.assign_mask <= pwdata[7:0];
            pgao_pkg::OFS_INVERT: cfg_r.invert_mask <= pwdata[7:0];
            pgao_pkg::OFS_POLARITY:
               cfg_r.polarity <= pgao_pkg::pgao_pol_t'(pwdata[0]);
            pgao_pkg::OFS_IRQ_MASK: irq_mask_r <= pwdata[2:0];
            default: access_r <= access_r;
         endcase
      end
   end

   // Sticky status: a new event beats a same-cycle clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_stat_r <= 3'h0;
      end else if (wr_en && pready && paddr == pgao_pkg::OFS_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_ev;
      end else begin
         irq_stat_r <= irq_stat_r | irq_ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_drive <= 1'b0;
         leader_ref <= 1'b0;
         irq <= 1'b0;
      end else begin
         out_drive <= out_nxt;
         // Own wave feeds the speed loop even in logic mode
         leader_ref <= leader_self & gen_wave;
         irq <= |((irq_stat_r | irq_ev) & irq_mask_r);
      end
   end

   property p_logic_follows;
      @(posedge clk_sys) disable iff (reset)
      mode_r == pgao_pkg::PGAO_MODE_LOGIC |=> out_drive == $past(logic_out);
   endproperty
   a_logic_follows: assert property (p_logic_follows)
      else $error("logic output did not follow in one cycle");

   property p_or_combine;
      @(posedge clk_sys) disable iff (reset)
      (mode_r == pgao_pkg::PGAO_MODE_LOGIC
         && cfg_r.polarity == pgao_pkg::PGAO_POL_NO
         && (drive_status & cfg_r.assign_mask & ~cfg_r.invert_mask) != 0)
      |=> out_drive;
   endproperty
   a_or_combine: assert property (p_or_combine)
      else $error("active condition did not drive output");

   property p_stall_bit;
      @(posedge clk_sys) disable iff (reset)
      (mode_r == pgao_pkg::PGAO_MODE_LOGIC && cfg_r.assign_mask == 8'h01
         && cfg_r.invert_mask == 8'h00 && !cfg_r.polarity)
      |=> out_drive == $past(drive_status[pgao_pkg::COND_STALL]);
   endproperty
   a_stall_bit: assert property (p_stall_bit)
      else $error("stall bit not routed to output");

   property p_nc_idle;
      @(posedge clk_sys) disable iff (reset)
      (mode_r == pgao_pkg::PGAO_MODE_LOGIC && cfg_r.assign_mask == 8'h00
         && cfg_r.polarity == pgao_pkg::PGAO_POL_NC) |=> out_drive;
   endproperty
   a_nc_idle: assert property (p_nc_idle)
      else $error("normally closed output not active at idle");

   property p_invert;
      @(posedge clk_sys) disable iff (reset)
      (mode_r == pgao_pkg::PGAO_MODE_LOGIC && cfg_r.polarity == 1'b0
         && (~drive_status & cfg_r.assign_mask & cfg_r.invert_mask) != 0)
      |=> out_drive;
   endproperty
   a_invert: assert property (p_invert)
      else $error("inverted condition ignored");

   property p_gen_mode;
      @(posedge clk_sys) disable iff (reset)
      mode_r == pgao_pkg::PGAO_MODE_GEN |=> out_drive == $past(gen_wave);
   endproperty
   a_gen_mode: assert property (p_gen_mode)
      else $error("generator mode output not from generator");

   property p_zero_rate;
      @(posedge clk_sys) disable iff (reset)
      (rate_r == 14'h0000)[*3] |-> !gen_wave && !gen_pulse;
   endproperty
   a_zero_rate: assert property (p_zero_rate)
      else $error("pulses produced at zero rate");

   property p_rate_range;
      @(posedge clk_sys) disable iff (reset)
      rate_r <= pgao_pkg::RATE_MAX;
   endproperty
   a_rate_range: assert property (p_rate_range)
      else $error("rate outside programmable range");

   property p_panel_lock;
      @(posedge clk_sys) disable iff (reset)
      (edit_rise && !panel_ok && !wr_en) |=> $stable(rate_r);
   endproperty
   a_panel_lock: assert property (p_panel_lock)
      else $error("panel edit accepted while locked");

   property p_rate_write;
      @(posedge clk_sys) disable iff (reset)
      (wr_en && pready && paddr == pgao_pkg::OFS_RATE && wrate_ok
         && !edit_rise) |=> rate_r == $past(wrate);
   endproperty
   a_rate_write: assert property (p_rate_write)
      else $error("rate write did not take effect");
endmodule : pgao_top
`default_nettype wire

// ===== pgao_follower.sv
/*
 Follower load on the shared open-collector line and the leader input.
 Assumes one clock domain shared with the block under test.
*/
`timescale 1ns/1ps
`default_nettype none
module pgao_follower (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic out_drive,
   input wire logic leader_ref,
   output logic line_level,
   output var int line_edges,
   output var int leader_edges
);
   logic line_d_r;
   logic lead_d_r;
   // Pull-up resistor: line is low while the transistor conducts
   assign line_level = ~out_drive;
   always_ff @(posedge clk_sys) begin
      line_d_r <= line_level;
      lead_d_r <= leader_ref;
      if (reset) begin
         line_edges <= 0;
         leader_edges <= 0;
      end else begin
         if (line_level !== line_d_r)
            line_edges <= line_edges + 1;
         if (leader_ref !== lead_d_r)
            leader_edges <= leader_edges + 1;
      end
   end
endmodule : pgao_follower
`default_nettype wire

// ===== pgao_tb_top.sv
/*
 Self-checking bench for the pulse generator / assignable output block.
 Assumes an APB slave that raises pready; the master waits for it.
*/
`timescale 1ns/1ps
`default_nettype none
module pgao_tb_top;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
   logic panel_edit, leader_self, out_drive, leader_ref, irq, line_level;
   logic [7:0] paddr, drive_status;
   logic [31:0] pwdata, prdata, q;
   logic [13:0] panel_rate;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int line_edges, leader_edges;
   logic [7:0] ca [9] = '{8'h01, 8'h01, 8'h30, 8'h30, 8'h30, 8'h01, 8'h01,
      8'h80, 8'h00};
   logic [7:0] ci [9] = '{0, 0, 0, 0, 0, 8'h01, 0, 0, 8'hFF};
   logic [7:0] cs [9] = '{8'h01, 0, 8'h10, 8'h20, 8'h0F, 0, 8'h01, 8'h80, 0};
   logic [8:0] cp = 9'h040;
   logic [8:0] ce = 9'h0AD;

   pgao_top u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_status(drive_status), .panel_edit(panel_edit),
      .panel_rate(panel_rate), .leader_self(leader_self),
      .out_drive(out_drive), .leader_ref(leader_ref), .irq(irq));
   pgao_follower u_load (.clk_sys(clk_sys), .reset(reset),
      .out_drive(out_drive), .leader_ref(leader_ref),
      .line_level(line_level), .line_edges(line_edges),
      .leader_edges(leader_edges));

   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   // Hang guard well above the longest scenario
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // Starts on a clock edge, so callers may come from settle
   task automatic apb(input logic wr, input logic [7:0] a, input [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      q = prdata;
      err = pslverr;
      chk("pready", pready, 1);
      psel <= 0;
      penable <= 0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk("read", q, e);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : settle

   task automatic t_reset_map;
      logic [7:0] ofs [8] = '{0, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C,
         8'h20};
      foreach (ofs[i])
         rd(ofs[i], 0);
      apb(0, 8'h28, 0);
      chk("unmapped err", err, 1);
      chk("unmapped data", q, 0);
   endtask : t_reset_map

   task automatic t_rate;
      apb(1, pgao_pkg::OFS_RATE, 32'h0000_270F);
      rd(pgao_pkg::OFS_RATE, 32'h0000_270F);
      apb(1, pgao_pkg::OFS_RATE, 32'h0000_2710);
      rd(pgao_pkg::OFS_RATE, 32'h0000_270F);
      apb(1, pgao_pkg::OFS_RATE, 0);
      apb(1, pgao_pkg::OFS_MODE, 0);
      leader_self <= 1;
      settle(200);
      chk("gen idle", out_drive, 0);
      chk("line edges", line_edges, 0);
      chk("leader edges", leader_edges, 0);
   endtask : t_rate

   task automatic t_logic;
      apb(1, pgao_pkg::OFS_MODE, 1);
      foreach (ca[i]) begin
         apb(1, pgao_pkg::OFS_ASSIGN, {24'h0, ca[i]});
         apb(1, pgao_pkg::OFS_INVERT, {24'h0, ci[i]});
         apb(1, pgao_pkg::OFS_POLARITY, {31'h0, cp[i]});
         drive_status <= cs[i];
         settle(1);
         chk("out", out_drive, ce[i]);
         rd(pgao_pkg::OFS_STATUS, {23'h0, ce[i], cs[i]});
      end
   endtask : t_logic

   task automatic panel(input logic [13:0] v);
      panel_rate <= v;
      repeat (4) @(posedge clk_sys);
      panel_edit <= 1;
      repeat (8) @(posedge clk_sys);
      panel_edit <= 0;
      repeat (4) @(posedge clk_sys);
   endtask : panel

   task automatic t_panel;
      logic [31:0] exp;
      exp = 0;
      rd(pgao_pkg::OFS_IRQ_STAT, 32'h0000_0002);
      apb(1, pgao_pkg::OFS_IRQ_STAT, 7);
      apb(1, pgao_pkg::OFS_IRQ_MASK, 4);
      for (int a = 0; a < 4; a++) begin
         apb(1, pgao_pkg::OFS_ACCESS, a);
         panel(14'h0100 + 14'(a));
         if (a >= 2)
            exp = 32'h0000_0100 + a;
         rd(pgao_pkg::OFS_RATE, exp);
         settle(1);
         chk("irq", irq, a < 2);
         apb(1, pgao_pkg::OFS_IRQ_STAT, 4);
      end
      panel(14'h2710);
      rd(pgao_pkg::OFS_RATE, exp);
      rd(pgao_pkg::OFS_PANEL_RATE, 32'h0000_2710);
      apb(1, pgao_pkg::OFS_IRQ_MASK, 0);
      settle(1);
      chk("irq masked", irq, 0);
      apb(0, pgao_pkg::OFS_IRQ_STAT, 0);
      chk("stat bit", q[2], 1);
      apb(1, pgao_pkg::OFS_IRQ_MASK, 4);
      settle(1);
      chk("irq unmasked", irq, 1);
      apb(1, pgao_pkg::OFS_IRQ_STAT, 4);
      settle(1);
      chk("irq cleared", irq, 0);
   endtask : t_panel

   initial begin
      reset = 1;
      {psel, penable, pwrite, panel_edit, leader_self} = 0;
      paddr = 0;
      pwdata = 0;
      drive_status = 0;
      panel_rate = 0;
      repeat (20) @(posedge clk_sys);
      reset <= 0;
      @(posedge clk_sys);
      t_reset_map();
      t_rate();
      t_logic();
      t_panel();
      wrap_up();
   end
endmodule : pgao_tb_top
`default_nettype wire
